// >>> shared/e3ts_regs.svh
// Register map, field positions, reset values and frame geometry constants.
// Assumes inclusion by bare name from the design file; the bench files do not include it.
`ifndef E3TS_REGS_SVH
`define E3TS_REGS_SVH

`define E3TS_ADDR_CTRL      8'h00
`define E3TS_ADDR_OVH_INS1  8'h04
`define E3TS_ADDR_OVH_INS2  8'h08
`define E3TS_ADDR_OVH_VAL   8'h0c
`define E3TS_ADDR_STATUS    8'h10

`define E3TS_CTRL_MODE_LSB  0
`define E3TS_CTRL_DIR_LSB   2
`define E3TS_CTRL_MRK_BIT   4
`define E3TS_CTRL_EN_BIT    5
`define E3TS_INS1_GROUPS    4
`define E3TS_INS2_GROUPS    2
`define E3TS_VAL_A_BIT      0
`define E3TS_VAL_N_BIT      1
`define E3TS_VAL_MA_LSB     8
`define E3TS_VAL_NR_LSB     16
`define E3TS_VAL_GC_LSB     24
`define E3TS_STAT_RUN_BIT   0
`define E3TS_STAT_ILL_BIT   1
`define E3TS_STAT_POS_LSB   16

`define E3TS_CTRL_RST       6'h00
`define E3TS_SRC_SEL_RST    12'ha2a
`define E3TS_OVH_VAL_RST    32'hffff_0000

`define E3TS_DS3_FRAME_BITS  13'h1298
`define E3TS_G751_FRAME_BITS 13'h0600
`define E3TS_G751_SET_BITS   13'h0180
`define E3TS_G751_FAS_BITS   13'h000a
`define E3TS_G751_A_POS      13'h000a
`define E3TS_G751_N_POS      13'h000b
`define E3TS_G751_CJ_END     13'h0004
`define E3TS_G751_STF_END    13'h0008
`define E3TS_G751_SYNC_LAST  13'h0180
`define E3TS_G751_FAS_PAT    10'h3d0
`define E3TS_G832_FRAME_BITS 13'h10c8
`define E3TS_G832_FA1_BYTE   10'h000
`define E3TS_G832_FA2_BYTE   10'h001
`define E3TS_G832_EM_BYTE    10'h03c
`define E3TS_G832_TR_BYTE    10'h078
`define E3TS_G832_MA_BYTE    10'h0b4
`define E3TS_G832_NR_BYTE    10'h0f0
`define E3TS_G832_GC_BYTE    10'h12c
`define E3TS_G832_FA1_PAT    8'hf6
`define E3TS_G832_FA2_PAT    8'h28
`define E3TS_G832_TR_AUTO    8'h00
`define E3TS_G832_NR_AUTO    8'hff
`define E3TS_G832_GC_AUTO    8'hff

`define E3TS_MASK_ALL       4'hf
`define E3TS_MASK_FRAME     4'hd
`define E3TS_MASK_JUST      4'hc
`define E3TS_MASK_EM        4'h5

`endif

// >>> shared/e3ts_pkg.sv
// Types shared by the transmit sync and overhead sourcing block.
// Assumes the register constants come from e3ts_regs.svh.
package e3ts_pkg;
  typedef enum logic [1:0] {
    MODE_G751,
    MODE_G832,
    MODE_DS3_M13,
    MODE_DS3_CBIT
  } e3ts_mode_t;

  typedef enum logic [1:0] {
    SRC_AUTO,
    SRC_REG,
    SRC_DATA,
    SRC_PIN
  } e3ts_src_t;

  typedef enum logic [1:0] {
    DIR_HIZ,
    DIR_IN,
    DIR_OUT,
    DIR_RSVD
  } e3ts_dir_t;

  typedef enum logic [2:0] {
    GRP_0,
    GRP_1,
    GRP_2,
    GRP_3,
    GRP_4,
    GRP_5,
    GRP_NONE
  } e3ts_grp_t;
endpackage

// >>> shared/e3ts_pin_if.sv
// Carrier for synchronised transmit pin levels and clock edge pulses.
// Assumes both ends run on sys_clk.
interface e3ts_pin_if;
  logic clk_rise;
  logic clk_fall;
  logic data_lvl;
  logic ovh_lvl;
  logic sync_lvl;

  modport src (output clk_rise, output clk_fall, output data_lvl, output ovh_lvl,
               output sync_lvl);
  modport dst (input clk_rise, input clk_fall, input data_lvl, input ovh_lvl,
               input sync_lvl);
endinterface

// >>> hw/e3ts_pin_sync.sv
// Three-stage pin synchronisers and transmit clock edge detection.
// Assumes pins are asynchronous to sys_clk, which runs well above the pin clock.
module e3ts_pin_sync
  import e3ts_pkg::*;
#(
  parameter int unsigned N_PINS = 4
) (
  input  logic              sys_clk,
  input  logic              rst,
  input  logic [N_PINS-1:0] pin_raw,
  e3ts_pin_if.src           pins
);
  logic [N_PINS-1:0] s1_ff;
  logic [N_PINS-1:0] s2_ff;
  logic [N_PINS-1:0] s3_ff;
  logic [N_PINS-1:0] lvl_ff;
  logic              rise_ff;
  logic              fall_ff;

  // A change counts only once stages two and three agree, so a glitch is ignored.
  genvar i;
  generate
    for (i = 0; i < N_PINS; i++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1_ff[i]  <= 1'b0;
          s2_ff[i]  <= 1'b0;
          s3_ff[i]  <= 1'b0;
          lvl_ff[i] <= 1'b0;
        end else begin
          s1_ff[i] <= pin_raw[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (s2_ff[i] == s3_ff[i]) begin
            lvl_ff[i] <= s3_ff[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= s2_ff[0] & s3_ff[0] & ~lvl_ff[0];
      fall_ff <= ~s2_ff[0] & ~s3_ff[0] & lvl_ff[0];
    end
  end

  assign pins.clk_rise = rise_ff;
  assign pins.clk_fall = fall_ff;
  assign pins.data_lvl = lvl_ff[1];
  assign pins.ovh_lvl  = lvl_ff[2];
  assign pins.sync_lvl = lvl_ff[3];
endmodule

// >>> hw/e3ts_top.sv
// Transmit system-side frame sync and overhead sourcing for one E3 channel.
// Assumes an Avalon-MM master on sys_clk and system logic clocking the pins.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`include "e3ts_regs.svh"

module e3ts_top
  import e3ts_pkg::*;
(
  input  logic        sys_clk,
  input  logic        rst,
  input  logic [7:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  input  logic [3:0]  avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  input  logic        tx_clock_in,
  input  logic        tx_serial_data_in,
  input  logic        tx_overhead_in,
  input  logic        tx_frame_sync_in,
  output logic        tx_frame_sync_out,
  output logic        tx_frame_sync_oe,
  output logic        tx_gapped_clock,
  output logic        tx_overhead_clock,
  output logic        tx_framed_data,
  output logic        tx_framed_valid,
  input  logic        rx_remote_defect,
  input  logic        rx_remote_error
);
  e3ts_pin_if pins ();

  e3ts_pin_sync #(
    .N_PINS (4)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_raw ({tx_frame_sync_in, tx_overhead_in, tx_serial_data_in, tx_clock_in}),
    .pins    (pins)
  );

  e3ts_mode_t       mode_ff;
  e3ts_dir_t        dir_ff;
  logic             mrk_sel_ff;
  logic             enable_ff;
  logic [5:0][1:0]  src_sel_ff;
  logic [31:0]      ovh_val_ff;
  logic             restart_ff;
  logic             waitreq_ff;
  logic [31:0]      rdata_ff;
  logic [12:0]      pos_ff;
  logic             synced_ff;
  logic             prev_sync_ff;
  logic [7:0]       bip_acc_ff;
  logic [7:0]       bip_ff;
  logic             illegal_ff;
  logic             sync_out_ff;
  logic             sync_oe_ff;
  logic             gap_ff;
  logic             ovh_clk_ff;
  logic             data_out_ff;
  logic             valid_ff;

  logic             wr_go;
  logic [31:0]      wmask;
  logic [31:0]      rd_c;
  logic             resync_c;
  logic             running_c;
  logic [12:0]      cur_pos_c;
  logic [12:0]      frame_bits_c;
  e3ts_grp_t        grp_c;
  e3ts_src_t        sel_c;
  e3ts_src_t        eff_c;
  logic [12:0]      g751_off_c;
  logic [1:0]       g751_set_c;
  logic [2:0]       bb_c;
  logic [7:0]       auto_byte_c;
  logic [7:0]       reg_byte_c;
  logic             auto_bit_c;
  logic             reg_bit_c;
  logic             bit_c;
  logic             need_data_c;
  logic             need_pin_c;
  logic             start_hi_c;
  logic             illegal_c;

  localparam logic [9:0] G751_FAS_PAT = `E3TS_G751_FAS_PAT;

  // Allowed sources per mode and group, one bit per source code.
  function automatic logic [3:0] src_mask(e3ts_mode_t m, e3ts_grp_t g);
    logic [3:0] mk;
    mk = `E3TS_MASK_ALL;
    unique case (m)
      MODE_G751: begin
        if (g == GRP_0) mk = `E3TS_MASK_FRAME;
        else if (g == GRP_3 || g == GRP_4) mk = `E3TS_MASK_JUST;
      end
      MODE_G832: begin
        if (g == GRP_0 || g == GRP_2) mk = `E3TS_MASK_FRAME;
        else if (g == GRP_1) mk = `E3TS_MASK_EM;
      end
      MODE_DS3_M13: begin
        if (g == GRP_4) mk = `E3TS_MASK_JUST;
      end
      MODE_DS3_CBIT: begin
        if (g == GRP_4) mk = `E3TS_MASK_JUST;
        else if (g == GRP_5) mk = `E3TS_MASK_FRAME;
      end
    endcase
    return mk;
  endfunction

  // A function result cannot be bit-selected directly, so the mask is held first.
  function automatic logic src_ok(e3ts_mode_t m, e3ts_grp_t g, e3ts_src_t s);
    logic [3:0] mk;
    mk = src_mask(m, g);
    return mk[s];
  endfunction

  // Avalon slave: one wait cycle, then the answer stands for one cycle.
  assign wr_go = avs_write & ~waitreq_ff;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  always_comb begin
    rd_c = 32'h0000_0000;
    unique case (avs_address)
      `E3TS_ADDR_CTRL: begin
        rd_c[`E3TS_CTRL_MODE_LSB +: 2] = mode_ff;
        rd_c[`E3TS_CTRL_DIR_LSB +: 2]  = dir_ff;
        rd_c[`E3TS_CTRL_MRK_BIT]       = mrk_sel_ff;
        rd_c[`E3TS_CTRL_EN_BIT]        = enable_ff;
      end
      `E3TS_ADDR_OVH_INS1: rd_c[7:0] = src_sel_ff[3:0];
      `E3TS_ADDR_OVH_INS2: rd_c[3:0] = src_sel_ff[5:4];
      `E3TS_ADDR_OVH_VAL:  rd_c = ovh_val_ff;
      `E3TS_ADDR_STATUS: begin
        rd_c[`E3TS_STAT_RUN_BIT]       = running_c;
        rd_c[`E3TS_STAT_ILL_BIT]       = illegal_ff;
        rd_c[`E3TS_STAT_POS_LSB +: 13] = pos_ff;
      end
      default: rd_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      waitreq_ff <= 1'b1;
      rdata_ff   <= 32'h0000_0000;
    end else if (!waitreq_ff) begin
      waitreq_ff <= 1'b1;
    end else if (avs_read || avs_write) begin
      waitreq_ff <= 1'b0;
      rdata_ff   <= avs_read ? rd_c : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {enable_ff, mrk_sel_ff, dir_ff, mode_ff} <= `E3TS_CTRL_RST;
      src_sel_ff <= `E3TS_SRC_SEL_RST;
      ovh_val_ff <= `E3TS_OVH_VAL_RST;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      if (wr_go && avs_address == `E3TS_ADDR_CTRL && avs_byteenable[0]) begin
        mode_ff    <= e3ts_mode_t'(avs_writedata[`E3TS_CTRL_MODE_LSB +: 2]);
        dir_ff     <= e3ts_dir_t'(avs_writedata[`E3TS_CTRL_DIR_LSB +: 2]);
        mrk_sel_ff <= avs_writedata[`E3TS_CTRL_MRK_BIT];
        enable_ff  <= avs_writedata[`E3TS_CTRL_EN_BIT];
        restart_ff <= 1'b1;
      end
      if (wr_go && avs_address == `E3TS_ADDR_OVH_INS1 && avs_byteenable[0]) begin
        src_sel_ff[3:0] <= avs_writedata[7:0];
      end
      if (wr_go && avs_address == `E3TS_ADDR_OVH_INS2 && avs_byteenable[0]) begin
        src_sel_ff[5:4] <= avs_writedata[3:0];
      end
      if (wr_go && avs_address == `E3TS_ADDR_OVH_VAL) begin
        ovh_val_ff <= (ovh_val_ff & ~wmask) | (avs_writedata & wmask);
      end
    end
  end

  // Input sync: a low-to-high change on a falling edge marks the first bit.
  assign resync_c  = (dir_ff == DIR_IN) & pins.sync_lvl & ~prev_sync_ff;
  assign running_c = enable_ff & ((dir_ff != DIR_IN) | synced_ff);
  assign cur_pos_c = resync_c ? 13'h0000 : pos_ff;
  assign bb_c      = 3'd7 - cur_pos_c[2:0];
  assign g751_set_c = 2'(cur_pos_c / `E3TS_G751_SET_BITS);
  assign g751_off_c = cur_pos_c % `E3TS_G751_SET_BITS;

  always_comb begin
    unique case (mode_ff)
      MODE_G751: frame_bits_c = `E3TS_G751_FRAME_BITS;
      MODE_G832: frame_bits_c = `E3TS_G832_FRAME_BITS;
      MODE_DS3_M13, MODE_DS3_CBIT: frame_bits_c = `E3TS_DS3_FRAME_BITS;
    endcase
  end

  // Overhead group of the bit at the next sampling edge.
  always_comb begin
    grp_c = GRP_NONE;
    if (mode_ff == MODE_G751) begin
      if (g751_set_c == 2'd0) begin
        if (g751_off_c < `E3TS_G751_FAS_BITS) grp_c = GRP_0;
        else if (g751_off_c == `E3TS_G751_A_POS) grp_c = GRP_1;
        else if (g751_off_c == `E3TS_G751_N_POS) grp_c = GRP_2;
      end else if (g751_off_c < `E3TS_G751_CJ_END) begin
        grp_c = GRP_3;
      end else if (g751_set_c == 2'd3 && g751_off_c < `E3TS_G751_STF_END) begin
        grp_c = GRP_4;
      end
    end else if (mode_ff == MODE_G832) begin
      unique case (cur_pos_c[12:3])
        `E3TS_G832_FA1_BYTE, `E3TS_G832_FA2_BYTE: grp_c = GRP_0;
        `E3TS_G832_EM_BYTE: grp_c = GRP_1;
        `E3TS_G832_TR_BYTE: grp_c = GRP_2;
        `E3TS_G832_MA_BYTE: grp_c = GRP_3;
        `E3TS_G832_NR_BYTE: grp_c = GRP_4;
        `E3TS_G832_GC_BYTE: grp_c = GRP_5;
        default: grp_c = GRP_NONE;
      endcase
    end
  end

  // illegal choices fall back to the data stream
  always_comb begin
    sel_c = SRC_DATA;
    if (grp_c != GRP_NONE) begin
      sel_c = e3ts_src_t'(src_sel_ff[grp_c]);
    end
    eff_c = src_ok(mode_ff, grp_c, sel_c) ? sel_c : SRC_DATA;
  end

  always_comb begin
    auto_byte_c = `E3TS_G832_TR_AUTO;
    auto_bit_c  = 1'b1;
    if (mode_ff == MODE_G751) begin
      if (grp_c == GRP_0) auto_bit_c = G751_FAS_PAT[4'd9 - 4'(g751_off_c)];
      else if (grp_c == GRP_1) auto_bit_c = rx_remote_defect;
    end else begin
      unique case (grp_c)
        GRP_0: begin
          auto_byte_c = cur_pos_c[3] ? `E3TS_G832_FA2_PAT : `E3TS_G832_FA1_PAT;
        end
        GRP_1: auto_byte_c = bip_ff;
        GRP_2: auto_byte_c = `E3TS_G832_TR_AUTO;
        GRP_3: auto_byte_c = {rx_remote_defect, rx_remote_error, 6'h00};
        GRP_4: auto_byte_c = `E3TS_G832_NR_AUTO;
        GRP_5: auto_byte_c = `E3TS_G832_GC_AUTO;
        GRP_NONE: auto_byte_c = `E3TS_G832_TR_AUTO;
      endcase
      auto_bit_c = auto_byte_c[bb_c];
    end
  end

  always_comb begin
    reg_byte_c = ovh_val_ff[`E3TS_VAL_MA_LSB +: 8];
    if (grp_c == GRP_4) reg_byte_c = ovh_val_ff[`E3TS_VAL_NR_LSB +: 8];
    else if (grp_c == GRP_5) reg_byte_c = ovh_val_ff[`E3TS_VAL_GC_LSB +: 8];
    reg_bit_c = reg_byte_c[bb_c];
    if (mode_ff == MODE_G751) begin
      reg_bit_c = (grp_c == GRP_2) ? ovh_val_ff[`E3TS_VAL_N_BIT] : ovh_val_ff[`E3TS_VAL_A_BIT];
    end
  end

  always_comb begin
    bit_c = pins.data_lvl;
    if (grp_c != GRP_NONE) begin
      unique case (eff_c)
        SRC_AUTO: bit_c = auto_bit_c;
        SRC_REG:  bit_c = reg_bit_c;
        SRC_DATA: bit_c = pins.data_lvl;
        // overhead taken from the overhead pin
        SRC_PIN:  bit_c = pins.ovh_lvl;
      endcase
    end
  end

  assign need_data_c = (grp_c == GRP_NONE) | (eff_c == SRC_DATA);
  assign need_pin_c  = (grp_c != GRP_NONE) & (eff_c == SRC_PIN);

  always_comb begin
    unique case (mode_ff)
      MODE_G751: start_hi_c = pos_ff <= `E3TS_G751_SYNC_LAST;
      MODE_G832: start_hi_c = pos_ff[12:3] <= `E3TS_G832_GC_BYTE;
      MODE_DS3_M13, MODE_DS3_CBIT: start_hi_c = pos_ff == 13'h0000;
    endcase
  end

  always_comb begin
    illegal_c = 1'b0;
    for (int g = 0; g < 6; g++) begin
      if (!src_ok(mode_ff, e3ts_grp_t'(g), e3ts_src_t'(src_sel_ff[g]))) illegal_c = 1'b1;
    end
  end

  // a sync rise takes the bit as frame start
  always_ff @(posedge sys_clk) begin
    if (rst || restart_ff || !enable_ff) begin
      pos_ff       <= 13'h0000;
      synced_ff    <= 1'b0;
      prev_sync_ff <= 1'b0;
      bip_acc_ff   <= 8'h00;
      bip_ff       <= 8'h00;
      data_out_ff  <= 1'b0;
      valid_ff     <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (pins.clk_fall) begin
        // a held sync level does not restart
        prev_sync_ff <= pins.sync_lvl;
        if (resync_c) synced_ff <= 1'b1;
        if (running_c || resync_c) begin
          data_out_ff <= bit_c;
          valid_ff    <= 1'b1;
          if (cur_pos_c == frame_bits_c - 13'h0001) begin
            pos_ff     <= 13'h0000;
            bip_ff     <= bip_acc_ff ^ (8'h01 << bb_c) & {8{bit_c}};
            bip_acc_ff <= 8'h00;
          end else begin
            pos_ff     <= cur_pos_c + 13'h0001;
            bip_acc_ff <= bip_acc_ff ^ ((8'h01 << bb_c) & {8{bit_c}});
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      illegal_ff <= 1'b0;
      sync_oe_ff <= 1'b0;
    end else begin
      illegal_ff <= illegal_c;
      sync_oe_ff <= dir_ff == DIR_OUT;
    end
  end

  // outputs are set on the rising edge; the gapped and overhead clocks clear on the falling edge
  always_ff @(posedge sys_clk) begin
    if (rst || !running_c) begin
      sync_out_ff <= 1'b0;
      gap_ff      <= 1'b0;
      ovh_clk_ff  <= 1'b0;
    end else if (pins.clk_rise) begin
      // with mrk_sel_ff clear, start output falls once per frame; with it set, it is low on each overhead bit
      sync_out_ff <= mrk_sel_ff ? (grp_c == GRP_NONE) : start_hi_c;
      gap_ff      <= need_data_c;
      ovh_clk_ff  <= need_pin_c;
    end else if (pins.clk_fall) begin
      gap_ff     <= 1'b0;
      ovh_clk_ff <= 1'b0;
    end
  end

  // pin timing relies on the documented clock rate
  assign avs_waitrequest   = waitreq_ff;
  assign avs_readdata      = rdata_ff;
  assign tx_frame_sync_out = sync_out_ff;
  assign tx_frame_sync_oe  = sync_oe_ff;
  assign tx_gapped_clock   = gap_ff;
  assign tx_overhead_clock = ovh_clk_ff;
  assign tx_framed_data    = data_out_ff;
  assign tx_framed_valid   = valid_ff;
endmodule

// >>> tb/e3ts_top_asserts.sv
// Port-level checks for the transmit sync and overhead block.
// Assumes it is bound to e3ts_top and sees only its ports.
module e3ts_top_asserts (
  input logic        sys_clk,
  input logic        rst,
  input logic [7:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        tx_frame_sync_out,
  input logic        tx_frame_sync_oe,
  input logic        tx_gapped_clock,
  input logic        tx_overhead_clock,
  input logic        tx_framed_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dir_ff;
  logic       en_ff;
  logic [2:0] age_ff;
  logic       ctrl_wr;
  logic       calm;
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0];
  assign calm = age_ff == 3'h7;
  // A control write restarts the framer, so pin checks wait until it has settled.
  always_ff @(posedge sys_clk) begin
    if (rst || ctrl_wr) begin
      age_ff <= 3'h0;
    end else if (!calm) begin
      age_ff <= age_ff + 3'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_ff <= 2'h0;
      en_ff <= 1'b0;
    end else if (ctrl_wr) begin
      dir_ff <= avs_writedata[3:2];
      en_ff <= avs_writedata[5];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_gap_rise;
    calm && $rose(tx_gapped_clock);
  endsequence
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read
      && !(avs_address inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !tx_frame_sync_oe
      && !tx_frame_sync_out && !tx_gapped_clock && !tx_overhead_clock && !tx_framed_valid)
    else $error("outputs active after reset");
  a_oe_dir_match: assert property (calm |-> tx_frame_sync_oe == (dir_ff == 2'h2))
    else $error("sync enable does not follow direction");
  a_quiet_disabled: assert property (calm && !en_ff |-> !tx_gapped_clock && !tx_overhead_clock
      && !tx_framed_valid)
    else $error("activity while disabled");
  a_clk_exclusive: assert property (!(tx_gapped_clock && tx_overhead_clock))
    else $error("both bit clocks high");
  a_gap_width: assert property (disable iff (rst || !calm)
      s_gap_rise |=> tx_gapped_clock [*3])
    else $error("gapped clock pulse too short");
  a_valid_spacing: assert property (tx_framed_valid |=> !tx_framed_valid [*3])
    else $error("bit strobes too close");
  a_sync_edge: assert property (calm && $changed(tx_frame_sync_out) |-> !tx_framed_valid)
    else $error("sync moved at a falling edge");
endmodule

bind e3ts_top e3ts_top_asserts e3ts_top_asserts_inst (.sys_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .tx_frame_sync_out, .tx_frame_sync_oe, .tx_gapped_clock, .tx_overhead_clock,
  .tx_framed_valid);

// >>> tb/e3ts_sys_model.sv
// System-side transmit source for clock, serial data, overhead and sync pins.
// Assumes sys_clk is the bench clock; each pin clock phase lasts 4 cycles.
module e3ts_sys_model #(
  parameter int FLEN = 1536
) (
  input  logic sys_clk,
  output logic tx_clock_in,
  output logic tx_serial_data_in,
  output logic tx_overhead_in,
  output logic tx_frame_sync_in,
  output logic last_data,
  output logic last_ovh
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_ff = 3'h0;
  int         pos_ff = 0;
  // The pin clock runs well below line rate because the block oversamples it.
  initial begin
    tx_clock_in = 1'b0;
    tx_serial_data_in = 1'b0;
    tx_overhead_in = 1'b0;
    tx_frame_sync_in = 1'b0;
  end
  always @(posedge sys_clk) begin
    ph_ff <= ph_ff + 3'h1;
    if (ph_ff == 3'h3) begin
      tx_clock_in <= 1'b1;
      tx_serial_data_in <= 1'($urandom);
      tx_overhead_in <= 1'($urandom);
      tx_frame_sync_in <= pos_ff < 2;
    end
    if (ph_ff == 3'h7) begin
      tx_clock_in <= 1'b0;
      last_data <= tx_serial_data_in;
      last_ovh <= tx_overhead_in;
      pos_ff <= (pos_ff + 1) % FLEN;
    end
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the transmit sync and overhead sourcing block.
// Assumes the system-side model drives the pins and sys_clk runs at 100 MHz.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_remote_defect = 1'b0;
  logic        rx_remote_error = 1'b0;
  logic        tx_clock_in, tx_serial_data_in, tx_overhead_in, tx_frame_sync_in;
  logic        tx_frame_sync_out, tx_frame_sync_oe, tx_gapped_clock, tx_overhead_clock;
  logic        tx_framed_data, tx_framed_valid, last_data, last_ovh;
  logic        gq, oq, sq, took_d, took_o, win, fs_on;
  logic [1:0]  an_exp;
  int          bidx = -1;
  int          n_gap, n_ovh, n_low, n_high, n_srise;
  int          fails = 0;
  int          num_checks = 0;
  localparam logic [9:0] FAS = 10'h3d0;

  e3ts_top e3ts_top_inst (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_clock_in, .tx_serial_data_in,
    .tx_overhead_in, .tx_frame_sync_in, .tx_frame_sync_out, .tx_frame_sync_oe,
    .tx_gapped_clock, .tx_overhead_clock, .tx_framed_data, .tx_framed_valid,
    .rx_remote_defect, .rx_remote_error);
  e3ts_sys_model e3ts_sys_model_inst (.sys_clk, .tx_clock_in, .tx_serial_data_in,
    .tx_overhead_in, .tx_frame_sync_in, .last_data, .last_ovh);

  always #5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 50) fails++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    @(posedge sys_clk);
    while (tx_framed_valid !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 100) fails++;
  endtask

  // Per-frame counts do not depend on where a window of whole frames starts.
  task automatic run_win(input int n);
    win = 1'b0;
    repeat (24) wait_valid();
    {n_gap, n_ovh, n_low, n_high, n_srise} = '0;
    win = 1'b1;
    repeat (n) wait_valid();
    win = 1'b0;
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction

  function automatic logic legal(input int m, input int s);
    if (m == 1) return s == 0 || s == 2;
    if (m == 3) return s != 1;
    return s >= 2;
  endfunction

  always @(negedge sys_clk) begin
    if (tx_gapped_clock === 1'b1 && !gq) begin
      took_d = 1'b1;
      n_gap++;
    end
    if (tx_overhead_clock === 1'b1 && !oq) begin
      took_o = 1'b1;
      n_ovh++;
    end
    if (tx_frame_sync_out === 1'b1 && !sq) begin
      bidx = 0;
      n_srise++;
    end
    if (tx_framed_valid === 1'b1) begin
      if (win && took_d) check(tx_framed_data, last_data);
      if (win && took_o) check(tx_framed_data, last_ovh);
      if (win && fs_on && bidx >= 0 && bidx < 10) check(tx_framed_data, FAS[9 - bidx]);
      if (win && fs_on && bidx == 10) check(tx_framed_data, an_exp[0]);
      if (win && fs_on && bidx == 11) check(tx_framed_data, an_exp[1]);
      if (tx_frame_sync_out === 1'b1) n_high++;
      else n_low++;
      if (bidx >= 0) bidx++;
      took_d = 1'b0;
      took_o = 1'b0;
    end
    gq = tx_gapped_clock;
    oq = tx_overhead_clock;
    sq = tx_frame_sync_out;
  end

  initial begin
    logic [31:0] d;
    logic [31:0] v;
    logic [31:0] w;
    logic [3:0]  be;
    logic [11:0] vec;
    int          tg;
    {win, fs_on, took_d, took_o} = 4'h0;
    void'($urandom(32'h0db0));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0, 4'hf, d);
    check(d, 32'h0);
    bus(1'b0, 8'h04, 32'h0, 4'hf, d);
    check(d & 32'hff, 32'h2a);
    bus(1'b0, 8'h10, 32'h0, 4'hf, d);
    check(d & 32'h3, 32'h2);
    bus(1'b1, 8'h14, 32'hffff_ffff, 4'hf, d);
    bus(1'b0, 8'h14, 32'h0, 4'hf, d);
    check(d, 32'h0);
    v = 32'hffff_0000;
    repeat (4) begin
      w = $urandom;
      be = 4'($urandom);
      bus(1'b1, 8'h0c, w, be, d);
      v = merge(v, w, be);
      bus(1'b0, 8'h0c, 32'h0, 4'hf, d);
      check(d & 32'hffff_ff03, v & 32'hffff_ff03);
    end
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 4; s++) begin
        tg = (m == 0) ? 3 : (m == 1) ? 1 : m + 2;
        vec = 12'haaa;
        vec[2*tg +: 2] = 2'(s);
        bus(1'b1, 8'h00, 32'(m), 4'h1, d);
        bus(1'b1, 8'h04, {24'h0, vec[7:0]}, 4'h1, d);
        bus(1'b1, 8'h08, {28'h0, vec[11:8]}, 4'h1, d);
        bus(1'b0, 8'h10, 32'h0, 4'hf, d);
        check(d[1], !legal(m, s));
      end
    end
    v = $urandom;
    bus(1'b1, 8'h0c, v, 4'hf, d);
    bus(1'b1, 8'h04, 32'h94, 4'h1, d);
    bus(1'b1, 8'h08, 32'hb, 4'h1, d);
    rx_remote_defect <= 1'($urandom);
    rx_remote_error <= 1'($urandom);
    an_exp = v[1:0];
    fs_on = 1'b1;
    bus(1'b1, 8'h00, 32'h28, 4'h1, d);
    run_win(1536);
    check(n_high, 385);
    check(n_srise, 1);
    check(n_gap, 1520);
    check(n_ovh, 4);
    fs_on = 1'b0;
    bus(1'b1, 8'h00, 32'h38, 4'h1, d);
    run_win(1536);
    check(n_low, 28);
    check(n_gap, 1520);
    fs_on = 1'b1;
    bus(1'b1, 8'h00, 32'h24, 4'h1, d);
    @(posedge tx_frame_sync_in);
    run_win(1536);
    check(n_high, 385);
    check(n_srise, 1);
    fs_on = 1'b0;
    bus(1'b1, 8'h04, 32'haa, 4'h1, d);
    bus(1'b1, 8'h08, 32'ha, 4'h1, d);
    bus(1'b1, 8'h00, 32'h39, 4'h1, d);
    run_win(4296);
    check(n_low, 56);
    check(n_gap, 4296);
    wrap_up();
  end

  // Up to about 86000 cycles are needed, so the limit still leaves a margin.
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule
